// >>> core/dmacr_chan.sv
// one channel: arm bit, start request, done flag and abort pulse
// assumes all strobes are single-cycle and on the system clock
`include "dmacr_cfg.svh"

module dmacr_chan (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	// software strobes for this channel
	input  wire logic                    arm_wr,
	input  wire logic                    arm_wdata,
	input  wire logic                    abort_wr,
	input  wire logic                    req_set,
	input  wire logic                    flag_clr,
	// transfer engine side
	input  wire dmacr_pkg::dmacr_ch_cfg_t cfg,
	input  wire logic                    hw_trigger,
	input  wire logic                    grant,
	input  wire logic                    xfer_done,
	// state
	output dmacr_pkg::dmacr_ch_state_t   state
);

	dmacr_pkg::dmacr_ch_state_t st_reg;
	dmacr_pkg::dmacr_ch_state_t st_next;
	logic                       repeating;
	logic                       hw_trigger_select_field_ok;

	always_comb begin
		st_next    = st_reg;
		repeating  = cfg.transfer_mode_field[1];
		hw_trigger_select_field_ok = hw_trigger && (cfg.trigger_select_field != `DMACR_TRIGGER_SELECT_FIELD_NONE);
		st_next.abort = 1'b0;
		// completion clears arm first so a same-cycle software write wins
		if (xfer_done && st_reg.arm && !repeating) begin
			st_next.arm = 1'b0;
		end
		if (abort_wr) begin
			// abort only hits channels selected in the same write
			st_next.abort = arm_wdata;
			if (arm_wdata) begin
				st_next.arm = 1'b0;
			end
		end else if (arm_wr) begin
			st_next.arm = arm_wdata;
		end
		if (grant) begin
			st_next.req = 1'b0;
		end
		if (req_set || hw_trigger_select_field_ok) begin
			st_next.req = 1'b1;
		end
		if (flag_clr) begin
			st_next.done_flag = 1'b0;
		end
		if (xfer_done) begin
			st_next.done_flag = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign state = st_reg;

endmodule

// >>> core/dmacr_ctrl.sv
// top of the dma arm/request control front end: sfr decode and channels
// assumes a single-cycle sfr port, one system clock, arbiter on same clock
`include "dmacr_cfg.svh"

module dmacr_ctrl #(
	parameter int NUM_CH = `DMACR_NUM_CH
) (
	// clock and reset
	input  wire logic                             SYS_CLK,
	input  wire logic                             RST_B,
	// special function register port
	input  wire dmacr_pkg::dmacr_sfr_req_t        SFR_REQ,
	output logic [7:0]                            SFR_RDATA,
	output logic                                  SFR_HIT,
	// per-channel configuration from the descriptors
	input  wire dmacr_pkg::dmacr_ch_cfg_t [NUM_CH-1:0] CH_CFG,
	// hardware trigger pulses, one per channel
	input  wire logic [NUM_CH-1:0]                TRIGGER_SELECT_FIELD_EVENT,
	// arbiter and transfer engine
	input  wire logic [NUM_CH-1:0]                GRANT,
	input  wire logic [NUM_CH-1:0]                XFER_DONE,
	output logic [NUM_CH-1:0]                     CH_PENDING,
	output logic [NUM_CH-1:0]                     CH_ARMED,
	output logic [NUM_CH-1:0]                     CH_ABORT,
	output logic [NUM_CH-1:0]                     DONE_FLAGS,
	// descriptor addresses
	output logic [15:0]                           CH0_DESC_ADDR,
	output logic [15:0]                           CH1TO4_DESC_BASE,
	output logic [NUM_CH-1:0][15:0]               CH_DESC_ADDR
);

	dmacr_pkg::dmacr_regs_t                r_reg;
	dmacr_pkg::dmacr_regs_t                r_next;
	dmacr_pkg::dmacr_ch_state_t [NUM_CH-1:0] ch_state;
	logic                                  wr_arm;
	logic                                  wr_req;
	logic                                  wr_flags;
	logic                                  abort_cmd;
	logic [7:0]                            arm_rd;
	logic [7:0]                            req_rd;
	logic [7:0]                            flags_rd;
	logic [NUM_CH-1:0]                     arm_vec;
	logic [NUM_CH-1:0]                     req_vec;
	logic [NUM_CH-1:0]                     flag_vec;
	logic [NUM_CH-1:0]                     abort_vec;
	logic [15:0]                           ch0_ptr;
	logic [15:0]                           base14_ptr;

	// zero-extend a channel vector into a register byte
	function automatic logic [7:0] to_byte(input logic [NUM_CH-1:0] v);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < NUM_CH; i++) begin
			b[i] = v[i];
		end
		return b;
	endfunction

	// channels 1 and up sit in consecutive slots from the shared base
	function automatic logic [15:0] slot_addr(input logic [15:0] base, input int idx);
		logic [15:0] ofs;
		ofs = 16'h0000;
		for (int k = 1; k < idx; k++) begin
			ofs = ofs + `DMACR_DESC_SLOT_BYTES;
		end
		return base + ofs;
	endfunction

	// write strobe for one register offset
	function automatic logic wr_at(input dmacr_pkg::dmacr_sfr_req_t r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// is this address one of ours; listed so a hole in the map cannot creep in
	function automatic logic is_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		unique case (a)
			`DMACR_OFS_DONE_FLAGS,
			`DMACR_OFS_BASE14_LO,
			`DMACR_OFS_BASE14_HI,
			`DMACR_OFS_CH0_LO,
			`DMACR_OFS_CH0_HI,
			`DMACR_OFS_ARM,
			`DMACR_OFS_REQ: begin
				hit = 1'b1;
			end
			default: begin
			end
		endcase
		return hit;
	endfunction

	assign wr_arm    = wr_at(SFR_REQ, `DMACR_OFS_ARM);
	assign wr_req    = wr_at(SFR_REQ, `DMACR_OFS_REQ);
	assign wr_flags  = wr_at(SFR_REQ, `DMACR_OFS_DONE_FLAGS);

	// assembled pointers, shared by the address outputs and the slot adder
	assign ch0_ptr    = {r_reg.ch0_hi, r_reg.ch0_lo};
	assign base14_ptr = {r_reg.base14_hi, r_reg.base14_lo};
	assign abort_cmd = wr_arm && SFR_REQ.wdata[`DMACR_ABORT_BIT];

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			dmacr_chan u_chan (
				.clk        (SYS_CLK),
				.rst_b      (RST_B),
				.arm_wr     (wr_arm),
				.arm_wdata  (SFR_REQ.wdata[g]),
				.abort_wr   (abort_cmd),
				// writing zero to a request bit leaves it alone
				.req_set    (wr_req && SFR_REQ.wdata[g]),
				.flag_clr   (wr_flags && !SFR_REQ.wdata[g]),
				.cfg        (CH_CFG[g]),
				.hw_trigger (TRIGGER_SELECT_FIELD_EVENT[g]),
				.grant      (GRANT[g]),
				.xfer_done  (XFER_DONE[g]),
				.state      (ch_state[g])
			);
			assign arm_vec[g]   = ch_state[g].arm;
			assign req_vec[g]   = ch_state[g].req;
			assign flag_vec[g]  = ch_state[g].done_flag;
			assign abort_vec[g] = ch_state[g].abort;
			// channel 0 has its own pointer; the rest share one base
			if (g == 0) begin : g_addr0
				assign CH_DESC_ADDR[g] = ch0_ptr;
			end else begin : g_addrn
				assign CH_DESC_ADDR[g] = slot_addr(base14_ptr, g);
			end
		end
	endgenerate

	// abort bit always reads zero; spare bits 6:5 read back
	always_comb begin
		arm_rd      = to_byte(arm_vec);
		arm_rd[6:5] = r_reg.arm_spare;
		arm_rd[`DMACR_ABORT_BIT] = 1'b0;
		req_rd      = to_byte(req_vec);
		flags_rd    = to_byte(flag_vec);
	end

	always_comb begin
		r_next = r_reg;
		if (SFR_REQ.wr) begin
			unique case (SFR_REQ.addr)
				`DMACR_OFS_BASE14_LO: begin
					r_next.base14_lo = SFR_REQ.wdata;
				end
				`DMACR_OFS_BASE14_HI: begin
					r_next.base14_hi = SFR_REQ.wdata;
				end
				`DMACR_OFS_CH0_LO: begin
					r_next.ch0_lo = SFR_REQ.wdata;
				end
				`DMACR_OFS_CH0_HI: begin
					r_next.ch0_hi = SFR_REQ.wdata;
				end
				`DMACR_OFS_ARM: begin
					r_next.arm_spare = SFR_REQ.wdata[6:5];
				end
				default: begin
					// done flags and request bits live in the channels
				end
			endcase
		end
		// read data registered: valid the cycle after the read strobe
		if (SFR_REQ.rd) begin
			unique case (SFR_REQ.addr)
				`DMACR_OFS_DONE_FLAGS: begin
					r_next.rdata = flags_rd;
				end
				`DMACR_OFS_BASE14_LO: begin
					r_next.rdata = r_reg.base14_lo;
				end
				`DMACR_OFS_BASE14_HI: begin
					r_next.rdata = r_reg.base14_hi;
				end
				`DMACR_OFS_CH0_LO: begin
					r_next.rdata = r_reg.ch0_lo;
				end
				`DMACR_OFS_CH0_HI: begin
					r_next.rdata = r_reg.ch0_hi;
				end
				`DMACR_OFS_ARM: begin
					r_next.rdata = arm_rd;
				end
				`DMACR_OFS_REQ: begin
					r_next.rdata = req_rd;
				end
				default: begin
					r_next.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			r_reg.ch0_lo    <= `DMACR_RESET_BYTE;
			r_reg.ch0_hi    <= `DMACR_RESET_BYTE;
			r_reg.base14_lo <= `DMACR_RESET_BYTE;
			r_reg.base14_hi <= `DMACR_RESET_BYTE;
			r_reg.arm_spare <= `DMACR_RESET_SPARE;
			r_reg.rdata     <= `DMACR_RESET_BYTE;
		end else begin
			r_reg <= r_next;
		end
	end

	// an unarmed channel never asks the arbiter, whatever its request
	assign CH_PENDING       = req_vec & arm_vec;
	assign CH_ARMED         = arm_vec;
	// abort is a single-cycle pulse; the engine must act on it at once
	assign CH_ABORT         = abort_vec;
	assign DONE_FLAGS       = flag_vec;
	assign CH0_DESC_ADDR    = ch0_ptr;
	assign CH1TO4_DESC_BASE = base14_ptr;
	assign SFR_RDATA        = r_reg.rdata;
	// combinational: tells the sfr mux this address belongs here
	assign SFR_HIT          = is_mapped(SFR_REQ.addr);

endmodule

// >>> dv/dmacr_asserts.sv
// port assertions for the dma arm/request front end
// assumes a bind from the bench top and the single system clock domain
`include "dmacr_cfg.svh"

module dmacr_asserts #(
	parameter int NUM_CH = 5
) (
	// clock and reset
	input wire logic                                 SYS_CLK,
	input wire logic                                 RST_B,
	// inputs
	input wire dmacr_pkg::dmacr_sfr_req_t            SFR_REQ,
	input wire dmacr_pkg::dmacr_ch_cfg_t [NUM_CH-1:0] CH_CFG,
	input wire logic [NUM_CH-1:0]                    TRIGGER_SELECT_FIELD_EVENT,
	input wire logic [NUM_CH-1:0]                    GRANT,
	input wire logic [NUM_CH-1:0]                    XFER_DONE,
	// outputs
	input wire logic [7:0]                           SFR_RDATA,
	input wire logic [NUM_CH-1:0]                    CH_PENDING,
	input wire logic [NUM_CH-1:0]                    CH_ARMED,
	input wire logic [NUM_CH-1:0]                    CH_ABORT,
	input wire logic [NUM_CH-1:0]                    DONE_FLAGS,
	input wire logic [15:0]                          CH0_DESC_ADDR,
	input wire logic [15:0]                          CH1TO4_DESC_BASE,
	input wire logic [NUM_CH-1:0][15:0]              CH_DESC_ADDR
);
	timeunit 1ns;
	timeprecision 1ps;

	logic              aw;
	logic              rw;
	logic [NUM_CH-1:0] nr;

	assign aw = SFR_REQ.wr && SFR_REQ.addr == `DMACR_OFS_ARM;
	assign rw = SFR_REQ.wr && SFR_REQ.addr == `DMACR_OFS_REQ;
	// non-repeating modes have the upper mode bit clear
	always_comb
		for (int i = 0; i < NUM_CH; i++)
			nr[i] = !CH_CFG[i].transfer_mode_field[1];

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	a_abort_stops: assert property (aw && SFR_REQ.wdata[7] |=>
		CH_ABORT == $past(SFR_REQ.wdata[NUM_CH-1:0]) && (CH_ARMED & CH_ABORT) == 0)
		else $error("abort write did not stop the selected channels");
	a_abort_quiet: assert property (aw && !SFR_REQ.wdata[7] |=>
		CH_ABORT == 0 && CH_ARMED == $past(SFR_REQ.wdata[NUM_CH-1:0]))
		else $error("plain arm write misbehaved");
	a_abort_rdzero: assert property (SFR_REQ.rd && SFR_REQ.addr == `DMACR_OFS_ARM |=>
		!SFR_RDATA[7]) else $error("abort bit read back as one");
	a_arm_gates: assert property ((CH_PENDING & ~CH_ARMED) == 0)
		else $error("unarmed channel pending");
	a_unarmed_idle: assert property (aw && !SFR_REQ.wdata[7] |=>
		(CH_PENDING & ~$past(SFR_REQ.wdata[NUM_CH-1:0])) == 0)
		else $error("disarmed channel still pending");
	a_req_starts: assert property (rw |=>
		(CH_ARMED & ~CH_PENDING & $past(SFR_REQ.wdata[NUM_CH-1:0])) == 0)
		else $error("request write did not start armed channel");
	a_grant_clears: assert property (GRANT != 0 && !rw && TRIGGER_SELECT_FIELD_EVENT == 0 |=>
		(CH_PENDING & $past(GRANT)) == 0) else $error("grant left request pending");
	a_done_flags: assert property (XFER_DONE != 0 |=>
		(DONE_FLAGS & $past(XFER_DONE)) == $past(XFER_DONE)) else $error("done flag not set");
	a_single_disarm: assert property ((XFER_DONE & nr) != 0 && !aw |=>
		(CH_ARMED & $past(XFER_DONE & nr)) == 0) else $error("single mode stayed armed");
	a_rep_stays: assert property ((XFER_DONE & ~nr & CH_ARMED) != 0 && !aw |=>
		(CH_ARMED & $past(XFER_DONE & ~nr)) == $past(XFER_DONE & ~nr & CH_ARMED))
		else $error("repeating mode lost arm");
	a_req_spare: assert property (SFR_REQ.rd && SFR_REQ.addr == `DMACR_OFS_REQ |=>
		SFR_RDATA[7:5] == 3'h0) else $error("unused request bits read nonzero");
	a_desc_slots: assert property (CH_DESC_ADDR[0] == CH0_DESC_ADDR &&
		CH_DESC_ADDR[NUM_CH-1] == CH1TO4_DESC_BASE + 16'((NUM_CH - 2) * 8))
		else $error("descriptor address wrong");
endmodule

// >>> dv/tb.sv
// self-checking bench for the dma arm/request front end
// assumes the package, header and dmacr_ctrl are compiled first
`include "dmacr_cfg.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                      sys_clk = 1'b0;
	logic                      rst_b = 1'b0;
	dmacr_pkg::dmacr_sfr_req_t sfr_req = '0;
	dmacr_pkg::dmacr_ch_cfg_t [4:0] ch_cfg;
	logic [4:0]                trigger_select_field_event = '0, grant = '0, xfer_done = '0;
	logic [4:0]                ch_pending, ch_armed, ch_abort, done_flags;
	logic [7:0]                sfr_rdata;
	logic                      sfr_hit;
	logic [15:0]               ch0_desc_addr, ch1to4_desc_base;
	logic [4:0][15:0]          ch_desc_addr;
	int                        errors = 0;
	int                        tests_run = 0;
	int                        cycles = 0;

	dmacr_ctrl #(.NUM_CH(5)) i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .SFR_REQ(sfr_req),
		.SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit), .CH_CFG(ch_cfg), .TRIGGER_SELECT_FIELD_EVENT(trigger_select_field_event),
		.GRANT(grant), .XFER_DONE(xfer_done), .CH_PENDING(ch_pending), .CH_ARMED(ch_armed),
		.CH_ABORT(ch_abort), .DONE_FLAGS(done_flags), .CH0_DESC_ADDR(ch0_desc_addr),
		.CH1TO4_DESC_BASE(ch1to4_desc_base), .CH_DESC_ADDR(ch_desc_addr));

	always #12.5 sys_clk = ~sys_clk;

	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// whole run is about 80 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle access; read data is settled at the closing falling edge
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge sys_clk);
		sfr_req = '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr(1'b0, a, 8'h00);
		check(16'(sfr_rdata), 16'(exp));
	endtask

	task automatic ev(input logic [4:0] g, input logic [4:0] t, input logic [4:0] d);
		@(negedge sys_clk);
		grant = g;
		trigger_select_field_event = t;
		xfer_done = d;
		@(negedge sys_clk);
		{grant, trigger_select_field_event, xfer_done} = '0;
	endtask

	initial begin
		// ch4 repeated block on trigger 3, ch3 repeated single, ch2 block, ch1/0 single
		ch_cfg = {7'h63, 7'h40, 7'h20, 7'h00, 7'h00};
		repeat (16) @(negedge sys_clk);
		rst_b = 1'b1;
		for (int a = 'hd1; a <= 'hd7; a++)
			rd(8'(a), 8'h00);
		sfr(1'b1, 8'hd0, 8'h55);
		rd(8'hd0, 8'h00);
		// decode flag follows the address alone, just outside and inside the map
		@(negedge sys_clk);
		sfr_req.addr = 8'hd0;
		@(negedge sys_clk);
		check(16'(sfr_hit), 16'h0000);
		sfr_req.addr = `DMACR_OFS_REQ;
		@(negedge sys_clk);
		check(16'(sfr_hit), 16'h0001);
		sfr_req = '0;
		sfr(1'b1, `DMACR_OFS_CH0_LO, 8'h34);
		sfr(1'b1, `DMACR_OFS_CH0_HI, 8'h12);
		sfr(1'b1, `DMACR_OFS_BASE14_LO, 8'h78);
		sfr(1'b1, `DMACR_OFS_BASE14_HI, 8'h56);
		rd(`DMACR_OFS_CH0_HI, 8'h12);
		rd(`DMACR_OFS_BASE14_LO, 8'h78);
		check(ch0_desc_addr, 16'h1234);
		check(ch1to4_desc_base, 16'h5678);
		for (int n = 1; n < 5; n++)
			check(ch_desc_addr[n], 16'h5678 + 16'(8 * (n - 1)));
		sfr(1'b1, `DMACR_OFS_ARM, 8'h7f);
		rd(`DMACR_OFS_ARM, 8'h7f);
		sfr(1'b1, `DMACR_OFS_REQ, 8'hff);
		rd(`DMACR_OFS_REQ, 8'h1f);
		check(16'(ch_pending), 16'h001f);
		sfr(1'b1, `DMACR_OFS_REQ, 8'h00);
		check(16'(ch_pending), 16'h001f);
		ev(5'h01, 5'h00, 5'h00);
		check(16'(ch_pending), 16'h001e);
		ev(5'h00, 5'h00, 5'h1e);
		check(16'(done_flags), 16'h001e);
		check(16'(ch_armed), 16'h0019);
		sfr(1'b1, `DMACR_OFS_DONE_FLAGS, 8'h1d);
		check(16'(done_flags), 16'h001c);
		rd(`DMACR_OFS_DONE_FLAGS, 8'h1c);
		sfr(1'b1, `DMACR_OFS_ARM, 8'h88);
		check(16'(ch_abort), 16'h0008);
		check(16'(ch_armed & 5'h08), 16'h0000);
		sfr(1'b0, `DMACR_OFS_ARM, 8'h00);
		check(16'(sfr_rdata & 8'h80), 16'h0000);
		sfr(1'b1, `DMACR_OFS_ARM, 8'h11);
		check(16'(ch_abort), 16'h0000);
		check(16'(ch_pending), 16'h0010);
		ev(5'h1f, 5'h00, 5'h00);
		check(16'(ch_pending), 16'h0000);
		ev(5'h00, 5'h11, 5'h00);
		check(16'(ch_pending), 16'h0010);
		sfr(1'b1, `DMACR_OFS_REQ, 8'h04);
		check(16'(ch_pending), 16'h0010);
		sfr(1'b1, `DMACR_OFS_ARM, 8'h01);
		check(16'(ch_pending), 16'h0000);
		wrap_up();
	end
endmodule

bind dmacr_ctrl dmacr_asserts #(.NUM_CH(NUM_CH)) i_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
	.SFR_REQ(SFR_REQ), .CH_CFG(CH_CFG), .TRIGGER_SELECT_FIELD_EVENT(TRIGGER_SELECT_FIELD_EVENT), .GRANT(GRANT),
	.XFER_DONE(XFER_DONE), .SFR_RDATA(SFR_RDATA), .CH_PENDING(CH_PENDING),
	.CH_ARMED(CH_ARMED), .CH_ABORT(CH_ABORT), .DONE_FLAGS(DONE_FLAGS),
	.CH0_DESC_ADDR(CH0_DESC_ADDR), .CH1TO4_DESC_BASE(CH1TO4_DESC_BASE),
	.CH_DESC_ADDR(CH_DESC_ADDR));

// >>> pkg/dmacr_cfg.svh
// constants for the dma channel arm/request control front end
// assumes an 8-bit special function register port on the system clock
//
// Functional notes
// - abort write stops channels whose arm bit set
// - abort reads zero; writing zero does nothing
// - channel transfers only while its arm bit set
// - non-repeating modes clear arm on completion
// - request bit one acts as one trigger
// - only clearing arm halts a started channel
// - request bit clears when channel is granted
// - channel 0 descriptor address from two bytes
// - one shared base for channels 1 to 4
// - shared base low byte rw, resets zero
// - done flag set on completion, cleared by zero
// - mode 00 single,01 block,10/11 repeated
// - trigger select 00000 means software start only
`ifndef DMACR_CFG_SVH
`define DMACR_CFG_SVH

`define DMACR_NUM_CH          5
`define DMACR_OFS_DONE_FLAGS  8'hd1
`define DMACR_OFS_BASE14_LO   8'hd2
`define DMACR_OFS_BASE14_HI   8'hd3
`define DMACR_OFS_CH0_LO      8'hd4
`define DMACR_OFS_CH0_HI      8'hd5
`define DMACR_OFS_ARM         8'hd6
`define DMACR_OFS_REQ         8'hd7
`define DMACR_ABORT_BIT       7
`define DMACR_RESET_BYTE      8'h00
`define DMACR_RESET_SPARE     2'h0
`define DMACR_TRIGGER_SELECT_FIELD_NONE       5'h00
`define DMACR_DESC_SLOT_BYTES 16'h0008

`endif

// >>> pkg/dmacr_pkg.sv
// types shared by the dma arm/request control front end
// assumes dmacr_cfg.svh is included by every user of the constants
package dmacr_pkg;

	// transfer mode field encodings; upper bit marks the repeating modes
	typedef enum logic [1:0] {
		DMACR_MODE_SINGLE     = 2'h0,
		DMACR_MODE_BLOCK      = 2'h1,
		DMACR_MODE_REP_SINGLE = 2'h2,
		DMACR_MODE_REP_BLOCK  = 2'h3
	} dmacr_mode_t;

	// special function register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmacr_sfr_req_t;

	// per-channel configuration from the descriptor
	typedef struct packed {
		dmacr_mode_t transfer_mode_field;
		logic [4:0]  trigger_select_field;
	} dmacr_ch_cfg_t;

	// state of one channel
	typedef struct packed {
		logic arm;
		logic req;
		logic done_flag;
		logic abort;
	} dmacr_ch_state_t;

	// register state of the top
	typedef struct packed {
		logic [7:0] ch0_lo;
		logic [7:0] ch0_hi;
		logic [7:0] base14_lo;
		logic [7:0] base14_hi;
		logic [1:0] arm_spare;
		logic [7:0] rdata;
	} dmacr_regs_t;

endpackage
